// file: core/sdc_pkg.sv
// Shared types and constants of the synchronous DRAM command timing core
// What this block does
// - Column commands may be issued on consecutive clocks.
// - Clock enable sampled low suspends the device one cycle later.
// - Clock enable sampled high resumes the device one cycle later.
// - Write mask applies to the data word sampled on the same edge.
// - Read outputs release two cycles after the mask is sampled high.
// - Precharge ends a read burst: outputs release after 3 or 2 cycles.
// - Read latency is programmable to two or three cycles.
package sdc_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int DQ_W = 16;
    localparam int MASK_W = 2;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int BL_W = 3;

    // ****************************************
    // Command codes {ras_n, cas_n, we_n}
    // ****************************************
    localparam logic [2:0] CMD_LMR = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // ****************************************
    // Mode word fields and address bits
    // ****************************************
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam logic [2:0] MODE_CL_TWO = 3'h2;
    localparam logic [2:0] MODE_CL_THREE = 3'h3;
    localparam int PRE_ALL_BIT = 10;

    // ****************************************
    // Cycle timing of the device side
    // ****************************************
    localparam int CLOCK_ENABLE_RECOVERY_CYC = 1;
    localparam int COLUMN_COMMAND_SPACING_CYC = 1;
    localparam int DQM_WRITE_LAT_CYC = 0;
    localparam int DQM_READ_RELEASE_CYC = 2;
    localparam int PRECHARGE_TO_OUTPUT_RELEASE_CL3 = 3;
    localparam int PRECHARGE_TO_OUTPUT_RELEASE_CL2 = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } sdc_cmd_t;

    typedef enum logic [2:0] {
        SDC_IDLE = 3'b001,
        SDC_READ = 3'b010,
        SDC_WRITE = 3'b100
    } sdc_burst_t;

    typedef struct packed {
        logic active;
        logic cl3;
        logic [BL_W-1:0] bl_m1;
        sdc_burst_t bst;
        logic [BL_W-1:0] bcnt;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic mem_vld;
        logic [BANK_W+COL_W-1:0] mem_addr;
        logic p1_vld;
        logic [DQ_W-1:0] p1_data;
        logic [DQ_W-1:0] out_data;
        logic [MASK_W-1:0] dqm_d1;
        logic [MASK_W-1:0] oe;
    } sdc_state_t;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_ACTIVE = 1'b0;
    localparam logic RST_CL3 = 1'b1;
    localparam logic [BL_W-1:0] RST_BL_M1 = 3'h0;
    localparam sdc_state_t SDC_ST_RST = '{
        active: RST_ACTIVE,
        cl3: RST_CL3,
        bl_m1: RST_BL_M1,
        bst: SDC_IDLE,
        default: '0
    };
endpackage : sdc_pkg

// file: core/sdc_mem.sv
// Byte-masked word memory with registered read data
`timescale 1ns/100ps
module sdc_mem #(
    parameter int DW = 16,
    parameter int AW = 10
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Write port
    input wire logic we_in,
    input wire logic [DW/8-1:0] be_in,
    input wire logic [DW-1:0] wdata_in,
    // Read port
    input wire logic re_in,
    input wire logic [AW-1:0] addr_in,
    output logic [DW-1:0] rdata_out
);
    localparam int DEPTH = 1 << AW;

    if (DW % 8 != 0 || AW < 1 || AW > 20) begin : g_bad_size
        $error("sdc_mem: unsupported width or depth");
    end

    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge mclk_in) begin
        if (we_in) begin
            for (int i = 0; i < DW / 8; i++) begin
                if (be_in[i]) begin
                    mem[addr_in][i*8 +: 8] <= wdata_in[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else if (re_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule : sdc_mem

// file: core/sdc_core.sv
// Device-side command, burst and output timing of the synchronous DRAM
`timescale 1ns/100ps
module sdc_core
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Command bus
    input wire logic cke_in,
    input wire sdc_cmd_t cmd_in,
    // Data bus and masks
    input wire logic [MASK_W-1:0] dqm_in,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic [MASK_W-1:0] dq_oe_out
);
    // ****************************************
    // Helpers
    // ****************************************
    // Advance a column, wrapping inside the burst block
    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] col,
                                                  input logic [BL_W-1:0] bl_m1);
        logic [COL_W-1:0] msk;
        logic [COL_W-1:0] inc;
        msk = {{(COL_W-BL_W){1'b0}}, bl_m1};
        inc = col + 8'h01;
        return (col & ~msk) | (inc & msk);
    endfunction : next_col

    // Burst length code to length minus one
    function automatic logic [BL_W-1:0] bl_decode(input logic [2:0] code);
        case (code)
            3'h0: return 3'h0;
            3'h1: return 3'h1;
            3'h2: return 3'h3;
            3'h3: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction : bl_decode

    // ****************************************
    // State and decode
    // ****************************************
    sdc_state_t st_r;
    sdc_state_t st_nxt;
    logic [DQ_W-1:0] mem_rdata;
    logic [2:0] op;
    logic cmd_sel;
    logic rd_acc;
    logic wr_acc;
    logic pre_hit;
    logic bst_acc;
    logic lmr_acc;
    logic stop;
    logic cont;
    logic mem_re;
    logic mem_we;
    logic [BANK_W+COL_W-1:0] mem_addr;
    logic [2:0] cl_code;
    logic [BANK_W+COL_W-1:0] cmd_col;
    logic [DQ_W-1:0] keep_bits;

    assign op = {cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
    assign cmd_sel = st_r.active && !cmd_in.cs_n;
    assign rd_acc = cmd_sel && op == CMD_RD;
    assign wr_acc = cmd_sel && op == CMD_WR;
    assign pre_hit = cmd_sel && op == CMD_PRE
        && (cmd_in.addr[PRE_ALL_BIT] || cmd_in.bank == st_r.bank);
    assign bst_acc = cmd_sel && op == CMD_BST;
    assign lmr_acc = cmd_sel && op == CMD_LMR;
    assign cl_code = cmd_in.addr[MODE_CL_LSB +: 3];
    assign cmd_col = {cmd_in.bank, cmd_in.addr[COL_W-1:0]};
    assign keep_bits = {{8{~dqm_in[1]}}, {8{~dqm_in[0]}}};
    // A new column command ends the running burst at once
    assign stop = rd_acc || wr_acc || pre_hit || bst_acc;
    assign cont = st_r.active && !stop && st_r.bcnt != '0;

    // ****************************************
    // Memory port
    // ****************************************
    assign mem_re = rd_acc || (cont && st_r.bst == SDC_READ);
    // Mask and data are taken on the command edge itself
    assign mem_we = wr_acc || (cont && st_r.bst == SDC_WRITE);
    assign mem_addr = (rd_acc || wr_acc) ? cmd_col
                                         : {st_r.bank, st_r.col};

    sdc_mem #(
        .DW(DQ_W),
        .AW(BANK_W + COL_W)
    ) u_mem (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .we_in(mem_we),
        .be_in(~dqm_in),
        .wdata_in(dq_in),
        .re_in(mem_re),
        .addr_in(mem_addr),
        .rdata_out(mem_rdata)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic nxt_vld;
        nxt_vld = 1'b0;
        st_nxt = st_r;
        st_nxt.active = cke_in;
        if (st_r.active) begin
            if (rd_acc || wr_acc) begin
                st_nxt.bst = (st_r.bl_m1 == '0) ? SDC_IDLE
                           : (rd_acc ? SDC_READ : SDC_WRITE);
                st_nxt.bank = cmd_in.bank;
                st_nxt.col = next_col(cmd_in.addr[COL_W-1:0], st_r.bl_m1);
                st_nxt.bcnt = st_r.bl_m1;
            end else if (cont) begin
                st_nxt.col = next_col(st_r.col, st_r.bl_m1);
                st_nxt.bcnt = st_r.bcnt - 3'h1;
                if (st_r.bcnt == 3'h1) begin
                    st_nxt.bst = SDC_IDLE;
                end
            end else begin
                st_nxt.bst = SDC_IDLE;
                st_nxt.bcnt = '0;
            end
            if (lmr_acc) begin
                st_nxt.bl_m1 = bl_decode(cmd_in.addr[MODE_BL_LSB +: 3]);
                if (cl_code == MODE_CL_TWO) begin
                    st_nxt.cl3 = 1'b0;
                end else if (cl_code == MODE_CL_THREE) begin
                    st_nxt.cl3 = 1'b1;
                end
            end
            // Read pipe: memory word, then one extra stage at latency three
            st_nxt.mem_vld = mem_re;
            st_nxt.mem_addr = mem_addr;
            st_nxt.p1_vld = st_r.mem_vld;
            st_nxt.p1_data = mem_rdata;
            nxt_vld = st_r.cl3 ? st_r.p1_vld : st_r.mem_vld;
            st_nxt.out_data = st_r.cl3 ? st_r.p1_data : mem_rdata;
            st_nxt.dqm_d1 = dqm_in;
            st_nxt.oe = {MASK_W{nxt_vld}} & ~st_r.dqm_d1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_r <= SDC_ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dq_out = st_r.out_data;
    assign dq_oe_out = st_r.oe;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_rd_cl2_open;
        rd_acc && !st_r.cl3 && dqm_in == '0;
    endsequence
    sequence s_rd_cl3;
        rd_acc && st_r.cl3;
    endsequence
    sequence s_pre_quiet;
        st_r.active && !rd_acc;
    endsequence

    a_suspend_freeze: assert property (
        !cke_in |-> ##2 ($stable(st_r.out_data) && $stable(st_r.bcnt) && $stable(st_r.oe))
    ) else $error("state moved while clock suspended");

    a_resume_read: assert property (
        cke_in ##1 (!cmd_in.cs_n && op == CMD_RD) |=> st_r.mem_vld
    ) else $error("read after resume not taken");

    a_back_to_back: assert property (
        rd_acc ##1 rd_acc |=> st_r.mem_vld && st_r.mem_addr == $past(cmd_col)
    ) else $error("second column command not taken");

    a_write_mask: assert property (
        wr_acc |=> ((u_mem.mem[$past(cmd_col)] ^ $past(dq_in)) & $past(keep_bits)) == '0
    ) else $error("write word or mask not applied on command edge");

    a_dqm_release: assert property (
        (st_r.active && dqm_in[0]) ##1 st_r.active |=> !dq_oe_out[0]
    ) else $error("output not released two cycles after mask");

    a_pre_cl3_release: assert property (
        (pre_hit && st_r.cl3) ##1 s_pre_quiet ##1 s_pre_quiet |=> dq_oe_out == '0
    ) else $error("output not released three cycles after precharge");

    a_pre_cl2_release: assert property (
        (pre_hit && !st_r.cl3) ##1 s_pre_quiet |=> dq_oe_out == '0
    ) else $error("output not released two cycles after precharge");

    a_cl2_latency: assert property (
        s_rd_cl2_open ##1 st_r.active |=> dq_oe_out == '1 && dq_out == $past(mem_rdata)
    ) else $error("latency two data missing");

    a_cl3_latency: assert property (
        s_rd_cl3 ##1 (st_r.active && dqm_in == '0) ##1 st_r.active |=> dq_oe_out == '1
    ) else $error("latency three data missing");

    a_stop_release: assert property (
        (bst_acc && !st_r.cl3) ##1 s_pre_quiet |=> dq_oe_out == '0
    ) else $error("output not released after burst stop");

    a_mode_cl_two: assert property (
        (lmr_acc && cl_code == MODE_CL_TWO) |=> !st_r.cl3
    ) else $error("latency two not programmed by mode load");

    a_mode_cl_three: assert property (
        (lmr_acc && cl_code == MODE_CL_THREE) |=> st_r.cl3
    ) else $error("latency three not programmed by mode load");
endmodule : sdc_core

// file: tb/sdc_ctl_model.sv
// Controller-side model driving command, clock enable, mask and write data pins
`timescale 1ns/100ps
module sdc_ctl_model
    import sdc_pkg::*;
(
    // Clock
    input wire logic mclk_in,
    // Pins toward the device
    output logic cke_out,
    output sdc_cmd_t cmd_out,
    output logic [MASK_W-1:0] dqm_out,
    output logic [DQ_W-1:0] dq_out
);
    // ****************************************
    // Command issue
    // ****************************************
    initial begin
        cke_out = 1'b1;
        cmd_out = {1'b1, CMD_NOP, 2'h0, 12'h0};
        dqm_out = 2'h0;
        dq_out = 16'h0;
    end

    // One command per edge; callers space them in whole cycles
    // Spacing after writes, mode load and wake-up
    // Column commands on consecutive edges, latency chosen for the clock
    task automatic issue(input logic [2:0] op, input logic [BANK_W-1:0] bank,
            input logic [ADDR_W-1:0] addr, input logic [DQ_W-1:0] data,
            input logic [MASK_W-1:0] mask, input logic cke);
        @(posedge mclk_in);
        cke_out <= cke;
        cmd_out <= {1'b0, op, bank, addr};
        dqm_out <= mask;
        dq_out <= (op == CMD_WR) ? data : ~dq_out;
    endtask : issue
endmodule : sdc_ctl_model

// file: tb/tb_sdram_command_timing.sv
// Self-checking bench for the device-side command timing core
`timescale 1ns/100ps
module tb_sdram_command_timing;
    import sdc_pkg::*;
    // ****************************************
    // Bench signals and scoreboard
    // ****************************************
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cke;
    sdc_cmd_t cmd;
    logic [MASK_W-1:0] dqm;
    logic [MASK_W-1:0] dq_oe;
    logic [DQ_W-1:0] dq_w;
    logic [DQ_W-1:0] dq_r;
    logic [DQ_W-1:0] mem [0:1023];
    logic [DQ_W-1:0] exp_dq [0:4095];
    logic [MASK_W-1:0] exp_oe [0:4095];
    int cyc = 0;
    int n_fail = 0;
    int total_checks = 0;
    int cl = 3;
    int bl = 1;
    logic last_cke = 1'b1;
    logic chk_on = 1'b0;

    always #10 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    sdc_ctl_model u_ctl (.mclk_in(mclk), .cke_out(cke), .cmd_out(cmd), .dqm_out(dqm),
        .dq_out(dq_w));
    sdc_core dut (.mclk_in(mclk), .rst_n_in(rst_n), .cke_in(cke), .cmd_in(cmd),
        .dqm_in(dqm), .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(dq_oe));

    task automatic check(input string what, input logic [DQ_W-1:0] seen,
            input logic [DQ_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h at cycle %0d", what, exp, seen, cyc);
        end
    endtask : check

    function automatic logic [DQ_W-1:0] bm(input logic [MASK_W-1:0] e);
        return {{8{e[1]}}, {8{e[0]}}};
    endfunction : bm

    always @(negedge mclk) begin
        if (chk_on) begin
            check("dq_oe_out", 16'(dq_oe), 16'(exp_oe[cyc]));
            check("dq_out", dq_r & bm(exp_oe[cyc]), exp_dq[cyc] & bm(exp_oe[cyc]));
        end
    end

    // Issue one command and record what the device must do with it
    task automatic op(input logic [2:0] c, input logic [BANK_W-1:0] b,
            input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d,
            input logic [MASK_W-1:0] m, input logic k = 1'b1);
        int e;
        logic [7:0] col;
        u_ctl.issue(c, b, a, d, m, k);
        e = cyc + 1;
        if (last_cke) begin
            if (c == CMD_LMR && a[6:5] == 2'h1) cl = int'(a[6:4]);
            if (c == CMD_LMR) bl = (a[2:0] < 3'h4) ? 1 << a[1:0] : 1;
            for (int i = 0; i < 2; i++) begin
                if (c == CMD_WR && !m[i]) mem[{b, a[7:0]}][i*8+:8] = d[i*8+:8];
            end
            if (c == CMD_RD || c == CMD_PRE || c == CMD_BST) begin
                for (int i = e + cl; i < e + cl + 8; i++) exp_oe[i] = 2'h0;
            end
            for (int i = 0; c == CMD_RD && i < bl; i++) begin
                col = (a[7:0] & ~8'(bl - 1)) | ((a[7:0] + 8'(i)) & 8'(bl - 1));
                exp_oe[e + cl + i] = 2'h3;
                exp_dq[e + cl + i] = mem[{b, col}];
            end
            exp_oe[e + DQM_READ_RELEASE_CYC] &= ~m;
        end
        last_cke = k;
    endtask : op

    task automatic nop(input int n);
        repeat (n) op(CMD_NOP, 2'h0, 12'h0, 16'h0, 2'($urandom));
    endtask : nop

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [1:0] b;
        logic [7:0] c0;
        void'($urandom(32'h252fb76a));
        for (int i = 0; i < 4096; i++) exp_oe[i] = 2'h0;
        b = 2'($urandom);
        c0 = 8'($urandom) & 8'hfc;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        chk_on = 1'b1;
        nop(2);
        for (int p = 0; p < 4; p++) begin
            op(CMD_LMR, 2'h0, {5'h0, p[0] ? 3'h3 : 3'h2, 1'b0, p[1] ? 3'h2 : 3'h0}, 16'h0, 2'h0);
            nop(2);
            op(CMD_ACT, b, 12'($urandom), 16'h0, 2'h0);
            nop(1);
            if (!p[1]) begin
                for (int i = 0; i < 4; i++) op(CMD_WR, b, {4'h0, c0 + 8'(i)}, 16'($urandom), 2'h0);
                for (int i = 0; i < 4; i++) begin
                    op(CMD_WR, b, {4'h0, c0 + 8'(i)}, 16'($urandom), 2'($urandom));
                end
                nop(1);
                for (int i = 0; i < 4; i++) op(CMD_RD, b, {4'h0, c0 + 8'(i)}, 16'h0, 2'($urandom));
                nop(4);
            end else begin
                // Burst cut by a stop, one cut by a read, then one cut by a precharge
                op(CMD_RD, b, {4'h0, c0 | 8'($urandom % 4)}, 16'h0, 2'h0);
                op(CMD_BST, b, 12'h0, 16'h0, 2'h0);
                nop(2);
                op(CMD_RD, b, {4'h0, c0 | 8'($urandom % 4)}, 16'h0, 2'h0);
                nop(2);
                op(CMD_RD, b, {4'h0, c0 | 8'($urandom % 4)}, 16'h0, 2'h0);
                nop(1);
            end
            op(CMD_PRE, b, 12'h0, 16'h0, 2'h0);
            nop(8);
        end
        // Suspend: commands while asleep and on the wake-up edge are lost
        op(CMD_ACT, b, 12'h0, 16'h0, 2'h0);
        nop(1);
        op(CMD_NOP, 2'h0, 12'h0, 16'h0, 2'h0, 1'b0);
        op(CMD_WR, b, {4'h0, c0}, 16'($urandom), 2'h0, 1'b0);
        op(CMD_WR, b, {4'h0, c0}, 16'($urandom), 2'h0, 1'b1);
        nop(1);
        op(CMD_RD, b, {4'h0, c0}, 16'h0, 2'h0);
        nop(8);
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end
endmodule : tb_sdram_command_timing
